/* rtl/motion_report_map.svh */
/*
  Register offsets, field positions, reset values and limits of the
  motion-report register group.
  Assumes inclusion by bare name from the design file.
*/
`ifndef MOTION_REPORT_MAP_SVH
`define MOTION_REPORT_MAP_SVH

// register offsets
`define MRR_ADDR_STATUS     7'h02
`define MRR_ADDR_X_DISP     7'h03
`define MRR_ADDR_Y_DISP     7'h04
`define MRR_ADDR_SURFACE    7'h05
`define MRR_ADDR_PIX_TOTAL  7'h06
`define MRR_ADDR_PIX_PEAK   7'h07
`define MRR_ADDR_CONFIG     7'h0a
`define MRR_ADDR_MOTION_CLR 7'h12
`define MRR_ADDR_LP_CFG_A   7'h2c
`define MRR_ADDR_LP_CFG_B   7'h2d

// motion status field positions
`define MRR_ST_PENDING      7
`define MRR_ST_LP_OK        5
`define MRR_ST_OVERFLOW     4
`define MRR_ST_FAULT        1
`define MRR_ST_CPI          0

// configuration field positions
`define MRR_CFG_ZERO_BIT    7
`define MRR_CFG_CPI_BIT     4
`define MRR_CFG_ONE_BIT     3

// reset values
`define MRR_RST_CONFIG      8'h49
`define MRR_RST_LP_CFG_A    8'h7f
`define MRR_RST_LP_CFG_B    8'h80
`define MRR_RST_BYTE        8'h00
`define MRR_RST_ACC         12'h000

// accumulator limits
`define MRR_ACC_MAX         14'sh07ff
`define MRR_ACC_MIN         14'sh3800
`define MRR_ACC_FULL_POS    12'sh7ff
`define MRR_ACC_FULL_NEG    12'sh800
`define MRR_BYTE_POS        12'sh07f
`define MRR_BYTE_NEG        12'shf80
`define MRR_TAKE_POS        8'sh7f
`define MRR_TAKE_NEG        8'sh80

// frame statistic ceilings
`define MRR_SURFACE_MAX     8'ha9
`define MRR_PIX_TOTAL_MAX   8'hdd

`endif

/* rtl/motion_report_pkg.sv */
/*
  Types shared by the motion-report register group.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package motion_report_pkg;

	typedef logic [6:0] reg_addr_t;

	// one register access from the serial decoder
	typedef struct packed {
		logic      rd;
		logic      wr;
		reg_addr_t addr;
		logic [7:0] wdata;
	} reg_req_s;

	// one frame's results from the navigation engine
	typedef struct packed {
		logic        valid;
		logic [1:0][7:0] delta;
		logic [9:0]  features;
		logic [15:0] pixel_total;
		logic [5:0]  peak;
	} frame_report_s;

endpackage : motion_report_pkg

/* rtl/motion_report_registers.sv */
/*
  Motion-report register group: motion status, read-clearing X and Y
  displacement with freeze on status read, saturating accumulators, and
  three frame statistics.
  Assumes a serial decoder on sys_clk issuing one-cycle rd/wr strobes and
  a navigation engine posting one-cycle frame results on sys_clk.
  Fault sense inputs come from pads and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "motion_report_map.svh"

module motion_report_registers (
	// clock, reset, enable
	input  wire logic                             sys_clk,
	input  wire logic                             sys_rst,
	input  wire logic                             clk_en,
	// register port from serial decoder
	input  wire motion_report_pkg::reg_req_s      reg_req,
	output logic [7:0]                            reg_rdata,
	output logic                                  reg_rvalid,
	// frame results
	input  wire motion_report_pkg::frame_report_s frame,
	// laser short sense pads, high when shorted to ground
	input  wire logic                             laser_bias_resistor_pin_gnd,
	input  wire logic                             laser_drive_pin_gnd,
	// live status
	output logic                                  motion_pending,
	output logic                                  laser_fault
);
	import motion_report_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// access decode

	logic       rd_go;
	logic       wr_go;
	logic       frame_go;
	logic       status_rd;
	logic       motion_clear;
	logic [1:0] disp_rd;

	assign rd_go        = clk_en & reg_req.rd;
	assign wr_go        = clk_en & reg_req.wr;
	assign frame_go     = clk_en & frame.valid;
	assign status_rd    = rd_go & (reg_req.addr == `MRR_ADDR_STATUS);
	assign motion_clear = wr_go & (reg_req.addr == `MRR_ADDR_MOTION_CLR);
	assign disp_rd[0]   = rd_go & (reg_req.addr == `MRR_ADDR_X_DISP);
	assign disp_rd[1]   = rd_go & (reg_req.addr == `MRR_ADDR_Y_DISP);

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0] config_bits;
	logic [7:0] lowpower_cfg_a;
	logic [7:0] lowpower_cfg_b;
	logic       resolution_flag;
	logic       lowpower_cfg_complement_ok;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			config_bits <= `MRR_RST_CONFIG;
		end else if (wr_go && reg_req.addr == `MRR_ADDR_CONFIG) begin
			// fixed bits are forced so a careless write cannot break them
			config_bits                    <= reg_req.wdata;
			config_bits[`MRR_CFG_ZERO_BIT] <= 1'b0;
			config_bits[`MRR_CFG_ONE_BIT]  <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lowpower_cfg_a <= `MRR_RST_LP_CFG_A;
			lowpower_cfg_b <= `MRR_RST_LP_CFG_B;
		end else if (wr_go) begin
			if (reg_req.addr == `MRR_ADDR_LP_CFG_A) begin
				lowpower_cfg_a <= reg_req.wdata;
			end
			if (reg_req.addr == `MRR_ADDR_LP_CFG_B) begin
				lowpower_cfg_b <= reg_req.wdata;
			end
		end
	end

	assign resolution_flag            = config_bits[`MRR_CFG_CPI_BIT];
	assign lowpower_cfg_complement_ok = (lowpower_cfg_a == ~lowpower_cfg_b);

	////////////////////////////////////////////////////////////////////////////
	// laser fault sense

	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_s3;
	logic [1:0] pin_state;
	logic [1:0] pin_agree;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
			pin_s3 <= 2'h0;
		end else if (clk_en) begin
			pin_s1 <= {laser_drive_pin_gnd, laser_bias_resistor_pin_gnd};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	assign pin_agree = ~(pin_s2 ^ pin_s3);

	// a level is taken only when two stages agree, filtering glitches
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_state <= 2'h0;
		end else if (clk_en) begin
			pin_state <= (pin_state & ~pin_agree) | (pin_s3 & pin_agree);
		end
	end

	assign laser_fault = |pin_state;

	////////////////////////////////////////////////////////////////////////////
	// per-axis accumulators and frozen displacement

	logic signed [11:0] accum [2];
	logic signed [7:0]  frozen [2];
	logic signed [7:0]  take [2];
	logic [1:0]         sat_hit;
	logic [1:0]         full_scale;
	logic [1:0]         axis_busy;

	genvar a;
	for (a = 0; a < 2; a++) begin : g_axis
		logic signed [7:0]  step;
		logic signed [13:0] sum;
		logic signed [11:0] next_accum;

		// clamp to one byte; the remainder stays for later read cycles
		always_comb begin
			if (accum[a] > `MRR_BYTE_POS) begin
				take[a] = `MRR_TAKE_POS;
			end else if (accum[a] < `MRR_BYTE_NEG) begin
				take[a] = `MRR_TAKE_NEG;
			end else begin
				take[a] = accum[a][7:0];
			end
		end

		// low resolution halves each frame's step
		always_comb begin
			step = $signed(frame.delta[a]);
			if (!resolution_flag) begin
				step = step >>> 1;
			end
		end

		always_comb begin
			sum = motion_clear ? 14'sh0000 : 14'(accum[a]);
			if (status_rd) begin
				sum = sum - 14'(take[a]);
			end
			if (frame_go) begin
				sum = sum + 14'(step);
			end
		end

		// saturate instead of wrapping: path data is lost but sign kept
		always_comb begin
			sat_hit[a] = 1'b0;
			if (sum > `MRR_ACC_MAX) begin
				next_accum = `MRR_ACC_FULL_POS;
				sat_hit[a] = 1'b1;
			end else if (sum < `MRR_ACC_MIN) begin
				next_accum = `MRR_ACC_FULL_NEG;
				sat_hit[a] = 1'b1;
			end else begin
				next_accum = sum[11:0];
			end
		end

		always_ff @(posedge sys_clk or posedge sys_rst) begin
			if (sys_rst) begin
				accum[a] <= `MRR_RST_ACC;
			end else if (clk_en) begin
				accum[a] <= next_accum;
			end
		end

		// a new freeze overwrites values the host never fetched
		always_ff @(posedge sys_clk or posedge sys_rst) begin
			if (sys_rst) begin
				frozen[a] <= `MRR_RST_BYTE;
			end else if (motion_clear) begin
				frozen[a] <= `MRR_RST_BYTE;
			end else if (status_rd) begin
				frozen[a] <= take[a];
			end else if (disp_rd[a]) begin
				frozen[a] <= `MRR_RST_BYTE;
			end
		end

		assign full_scale[a] = (accum[a] == `MRR_ACC_FULL_POS) ||
		                       (accum[a] == `MRR_ACC_FULL_NEG);
		assign axis_busy[a]  = (accum[a] != `MRR_RST_ACC) ||
		                       (frozen[a] != `MRR_RST_BYTE);
	end

	assign motion_pending = |axis_busy;

	////////////////////////////////////////////////////////////////////////////
	// overflow flag

	logic accum_overflow;
	logic ovf_release;

	assign ovf_release = (|disp_rd) & ~(|full_scale);

	// a new overflow in the release cycle wins
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			accum_overflow <= 1'b0;
		end else if (clk_en) begin
			if (|sat_hit) begin
				accum_overflow <= 1'b1;
			end else if (ovf_release) begin
				accum_overflow <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame statistics

	logic [7:0] surface_quality;
	logic [7:0] frame_pixel_total;
	logic [7:0] frame_peak_pixel;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			surface_quality <= `MRR_RST_BYTE;
		end else if (frame_go) begin
			if (frame.features[9:2] > `MRR_SURFACE_MAX) begin
				surface_quality <= `MRR_SURFACE_MAX;
			end else begin
				surface_quality <= frame.features[9:2];
			end
		end
	end

	// the clamp guards against an engine sum the pixel range cannot reach
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			frame_pixel_total <= `MRR_RST_BYTE;
		end else if (frame_go) begin
			if (frame.pixel_total[15:8] > `MRR_PIX_TOTAL_MAX) begin
				frame_pixel_total <= `MRR_PIX_TOTAL_MAX;
			end else begin
				frame_pixel_total <= frame.pixel_total[15:8];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			frame_peak_pixel <= `MRR_RST_BYTE;
		end else if (frame_go) begin
			frame_peak_pixel <= {2'h0, frame.peak};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data

	logic [7:0] motion_status;
	logic [7:0] next_rdata;

	always_comb begin
		motion_status                   = 8'h00;
		motion_status[`MRR_ST_PENDING]  = motion_pending;
		motion_status[`MRR_ST_LP_OK]    = lowpower_cfg_complement_ok;
		motion_status[`MRR_ST_OVERFLOW] = accum_overflow;
		motion_status[`MRR_ST_FAULT]    = laser_fault;
		motion_status[`MRR_ST_CPI]      = resolution_flag;
	end

	// values are those before this read's own side effects
	always_comb begin
		case (reg_req.addr)
			`MRR_ADDR_STATUS:    next_rdata = motion_status;
			`MRR_ADDR_X_DISP:    next_rdata = frozen[0];
			`MRR_ADDR_Y_DISP:    next_rdata = frozen[1];
			`MRR_ADDR_SURFACE:   next_rdata = surface_quality;
			`MRR_ADDR_PIX_TOTAL: next_rdata = frame_pixel_total;
			`MRR_ADDR_PIX_PEAK:  next_rdata = frame_peak_pixel;
			`MRR_ADDR_CONFIG:    next_rdata = config_bits;
			`MRR_ADDR_LP_CFG_A:  next_rdata = lowpower_cfg_a;
			`MRR_ADDR_LP_CFG_B:  next_rdata = lowpower_cfg_b;
			default:             next_rdata = 8'h00;
		endcase
	end

	// rvalid stretches while clk_en is low; the host must not count it twice
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rvalid <= 1'b0;
		end else if (clk_en) begin
			reg_rvalid <= rd_go;
		end
	end

	// rdata holds until the next read so a slow host can still fetch it
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= `MRR_RST_BYTE;
		end else if (rd_go) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule : motion_report_registers

`default_nettype wire

/* tb/motion_report_assertions.sv */
/*
  Port checker for motion_report_registers, bound below.
  Assumes one sys_clk domain with async sys_rst.
*/
`timescale 1ns/1ns
`default_nettype none
module motion_report_assertions (
	// clock, reset, enable
	input wire logic				sys_clk,
	input wire logic				sys_rst,
	input wire logic				clk_en,
	// register port
	input wire motion_report_pkg::reg_req_s		reg_req,
	input wire logic [7:0]				reg_rdata,
	input wire logic				reg_rvalid,
	// frame and pads
	input wire motion_report_pkg::frame_report_s	frame,
	input wire logic				laser_bias_resistor_pin_gnd,
	input wire logic				laser_drive_pin_gnd,
	// live status
	input wire logic				motion_pending,
	input wire logic				laser_fault
);
	import motion_report_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire rq = clk_en & reg_req.rd;
	wire [6:0] ad = reg_req.addr;
	////////////////////////////////////////
	sequence s_xrd;
		rq && ad == 7'h03;
	endsequence
	sequence s_st;
		rq && ad == 7'h02;
	endsequence
	property p_rvalid; rq |=> reg_rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_pend; s_st |=> reg_rdata[7] == $past(motion_pending); endproperty
	a_pend: assert property (p_pend) else $error("pending bit wrong");
	property p_flt; s_st |=> reg_rdata[1] == $past(laser_fault); endproperty
	a_flt: assert property (p_flt) else $error("fault bit wrong");
	property p_rsvd; s_st |=> reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'b00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("status spare bits set");
	// second read with no status read between must find the value gone
	property p_xclr; s_xrd ##1 !rq ##1 s_xrd |=> reg_rdata == 8'h00; endproperty
	a_xclr: assert property (p_xclr) else $error("x not cleared");
	property p_clr; clk_en && reg_req.wr && ad == 7'h12 && !frame.valid |=> !motion_pending;
	endproperty
	a_clr: assert property (p_clr) else $error("motion clear kept motion");
	property p_sq; rq && ad == 7'h05 |=> reg_rdata <= 8'ha9; endproperty
	a_sq: assert property (p_sq) else $error("quality above ceiling");
	property p_pix; rq && ad == 7'h06 |=> reg_rdata <= 8'hdd; endproperty
	a_pix: assert property (p_pix) else $error("pixel total above ceiling");
	property p_peak; rq && ad == 7'h07 |=> reg_rdata[7:6] == 2'b00; endproperty
	a_peak: assert property (p_peak) else $error("peak upper bits set");
	property p_pin; (clk_en && laser_bias_resistor_pin_gnd) [*6] |-> laser_fault; endproperty
	a_pin: assert property (p_pin) else $error("short not flagged");
endmodule : motion_report_assertions
bind motion_report_registers motion_report_assertions u_chk (.sys_clk(sys_clk),
	.sys_rst(sys_rst), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .frame(frame),
	.laser_bias_resistor_pin_gnd(laser_bias_resistor_pin_gnd),
	.laser_drive_pin_gnd(laser_drive_pin_gnd), .motion_pending(motion_pending),
	.laser_fault(laser_fault));
`default_nettype wire

/* tb/host_port_model.sv */
/*
  Host side of the register port: one strobe per access.
  Assumes the block answers a read one cycle after the strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
	// clock
	input wire logic				sys_clk,
	// register port
	output var motion_report_pkg::reg_req_s		reg_req,
	input wire logic [7:0]				reg_rdata,
	input wire logic				reg_rvalid
);
	import motion_report_pkg::*;
	initial reg_req = '0;
	////////////////////////////////////////
	// idle address and data are inverted so a stale value never looks valid
	task automatic rd(input reg_addr_t a, output logic [7:0] d, output logic ok);
		@(negedge sys_clk);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(negedge sys_clk);
		reg_req.rd = 1'b0;
		reg_req.addr = ~a;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask : rd
	task automatic wr(input reg_addr_t a, input logic [7:0] v);
		@(negedge sys_clk);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = v;
		@(negedge sys_clk);
		reg_req.wr = 1'b0;
		reg_req.addr = ~a;
		reg_req.wdata = ~v;
	endtask : wr
endmodule : host_port_model
`default_nettype wire

/* tb/motion_report_registers_tb.sv */
/*
  Self-checking bench for motion_report_registers.
  Assumes host_port_model and the bound checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module motion_report_registers_tb;
	import motion_report_pkg::*;
	logic		sys_clk, sys_rst, clk_en, pin_b, pin_d, rv, pend, flt, ok;
	reg_req_s	req;
	frame_report_s	frame;
	logic [7:0]	rdata, d;
	int		errors = 0, tests_run = 0, n;
	motion_report_registers dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_req(req), .reg_rdata(rdata), .reg_rvalid(rv), .frame(frame),
		.laser_bias_resistor_pin_gnd(pin_b), .laser_drive_pin_gnd(pin_d),
		.motion_pending(pend), .laser_fault(flt));
	host_port_model host (.sys_clk(sys_clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rv));
	////////////////////////////////////////
	task automatic chk(input string s, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic rc(input reg_addr_t a, input logic [7:0] e);
		host.rd(a, d, ok);
		chk("rvalid", 8'h01, {7'h00, ok});
		chk($sformatf("reg %h", a), e, d);
	endtask : rc
	task automatic fr(input logic [7:0] x, y, input logic [9:0] f, input logic [15:0] s,
		input logic [5:0] p);
		@(negedge sys_clk);
		frame = {1'b1, y, x, f, s, p};
		@(negedge sys_clk);
		frame.valid = 1'b0;
	endtask : fr
	task complete_run;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// hang guard
	initial begin
		#2000000;
		errors++;
		complete_run();
	end
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		pin_b = 1'b0;
		pin_d = 1'b0;
		frame = '0;
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		rc(7'h02, 8'h20);
		for (int i = 3; i < 9; i++) rc(i[6:0], 8'h00);
		// low resolution halves each step: 10 -> 5, -6 -> -3
		fr(8'h0a, 8'hfa, 10'h000, 16'h0000, 6'h00);
		chk("pending pin", 8'h01, {7'h00, pend});
		rc(7'h02, 8'ha0);
		rc(7'h03, 8'h05);
		rc(7'h03, 8'h00);
		rc(7'h04, 8'hfd);
		rc(7'h02, 8'h20);
		fr(8'h04, 8'h00, 10'h000, 16'h0000, 6'h00);
		rc(7'h02, 8'ha0);
		fr(8'h06, 8'h00, 10'h000, 16'h0000, 6'h00);
		rc(7'h02, 8'ha0);
		rc(7'h03, 8'h03);
		rc(7'h04, 8'h00);
		host.wr(7'h0a, 8'hd0);
		rc(7'h0a, 8'h58);
		rc(7'h02, 8'h21);
		host.wr(7'h2c, 8'h00);
		rc(7'h02, 8'h01);
		host.wr(7'h2c, 8'h7f);
		repeat (17) fr(8'h7f, 8'h80, 10'h000, 16'h0000, 6'h00);
		rc(7'h02, 8'hb1);
		rc(7'h03, 8'h7f);
		rc(7'h04, 8'h80);
		for (n = 1; n < 40; n++) begin
			host.rd(7'h02, d, ok);
			if (d[7] !== 1'b1) break;
			chk("overflow", 8'h00, {7'h00, d[4]});
			host.rd(7'h03, d, ok);
			host.rd(7'h04, d, ok);
		end
		chk("drain cycles", 8'h11, n[7:0]);
		chk("pending pin", 8'h00, {7'h00, pend});
		fr(8'h20, 8'h20, 10'h000, 16'h0000, 6'h00);
		host.wr(7'h12, 8'h00);
		rc(7'h02, 8'h21);
		fr(8'h00, 8'h00, 10'h3ff, 16'hffff, 6'h3f);
		rc(7'h05, 8'ha9);
		rc(7'h06, 8'hdd);
		rc(7'h07, 8'h3f);
		fr(8'h00, 8'h00, 10'h190, 16'h1234, 6'h05);
		rc(7'h05, 8'h64);
		rc(7'h06, 8'h12);
		rc(7'h07, 8'h05);
		// a gated frame and a gated read must leave no trace
		@(negedge sys_clk);
		clk_en = 1'b0;
		fr(8'h10, 8'h10, 10'h000, 16'h0000, 6'h00);
		host.rd(7'h02, d, ok);
		chk("gated rvalid", 8'h00, {7'h00, ok});
		clk_en = 1'b1;
		rc(7'h05, 8'h64);
		rc(7'h02, 8'h21);
		pin_b = 1'b1;
		repeat (8) @(negedge sys_clk);
		rc(7'h02, 8'h23);
		chk("fault pin", 8'h01, {7'h00, flt});
		pin_b = 1'b0;
		pin_d = 1'b1;
		repeat (8) @(negedge sys_clk);
		rc(7'h02, 8'h23);
		pin_d = 1'b0;
		repeat (8) @(negedge sys_clk);
		rc(7'h02, 8'h21);
		chk("fault pin", 8'h00, {7'h00, flt});
		complete_run();
	end
endmodule : motion_report_registers_tb
`default_nettype wire
